// ==== rpc_pkg.sv ====
// package for the rf path and band-pass calibration configuration bank
// assumes an 8-bit register bus with 10-bit byte addresses
package rpc_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam logic [9:0] RF_PATH_CONTROL_OFS        = 10'h089;
	localparam logic [9:0] BANDPASS_CAL_TIME_OFS      = 10'h08A;
	localparam logic [9:0] BANDPASS_CAL_BANDWIDTH_OFS = 10'h08B;
	localparam logic [7:0] RF_PATH_CONTROL_RST        = 8'h07;
	localparam logic [7:0] BANDPASS_CAL_TIME_RST      = 8'h07;
	localparam logic [7:0] BANDPASS_CAL_BANDWIDTH_RST = 8'h04;
	localparam int RF_PATH_DISABLE_BIT = 4;
	localparam int IF_ATT_MSB          = 3;
	localparam int CAL_DUR_MSB         = 3;
	localparam int CAL_BW_MSB          = 5;
	// calibration lasts txtal * CAL_MULT * (n + CAL_ADD)
	localparam int CAL_MULT = 80 * 7;
	localparam int CAL_ADD  = 4;
	localparam logic [5:0] CAL_BW_50K  = 6'h04;
	localparam logic [5:0] CAL_BW_80K  = 6'h0D;
	localparam logic [5:0] CAL_BW_125K = 6'h16;
	localparam logic [5:0] CAL_BW_200K = 6'h1F;
	localparam logic [5:0] CAL_BW_300K = 6'h27;
	localparam int NUM_REGS = 3;
endpackage

// ==== rpc_regs_if.sv ====
// bundle between the bank top and its register storage
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface rpc_regs_if;
	logic       wr_en;
	logic [1:0] wr_idx;
	logic [7:0] wr_data;
	logic [7:0] reg_q [3];
	modport top (output wr_en, output wr_idx, output wr_data, input reg_q);
	modport store (input wr_en, input wr_idx, input wr_data, output reg_q);
endinterface

// ==== rpc_reg_store.sv ====
// storage for the three configuration bytes with per-register write masks
// assumes writes are already decoded to an index by the top
`timescale 1ns/1ps
module rpc_reg_store
	import rpc_pkg::*;
(
	input  wire logic  core_clk_i,
	input  wire logic  arst_n_i,
	rpc_regs_if.store  bus
);
	localparam logic [7:0] RST_V [3] = '{RF_PATH_CONTROL_RST,
		BANDPASS_CAL_TIME_RST, BANDPASS_CAL_BANDWIDTH_RST};
	// only documented field bits can ever hold a one
	localparam logic [7:0] MASK_V [3] = '{8'h1F, 8'h0F, 8'h3F};
	logic [7:0] q_reg    [3];
	logic [7:0] q_next   [3];

	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : g_reg
			always_comb begin
				q_next[g] = q_reg[g];
				if (bus.wr_en && bus.wr_idx == 2'(g)) begin
					q_next[g] = bus.wr_data & MASK_V[g]; // R7
				end
			end
			always_ff @(posedge core_clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					q_reg[g] <= RST_V[g];
				end else begin
					q_reg[g] <= q_next[g];
				end
			end
			assign bus.reg_q[g] = q_reg[g];
		end
	endgenerate
endmodule

// ==== rpc_bank.sv ====
// top of the rf path and band-pass calibration configuration bank
// assumes a single-cycle strobe master on core_clk_i; no wait states
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// Overview of operation
// [R1] rf_path_disable at 1 switches the rf path off, at 0 (reset) on.
// [R2] the 4-bit if_attenuation_trim sets 0 to 12.0 dB in 0.8 dB steps.
// [R3] in single-down conversion software uses only codes 0101 to 1010.
// [R4] calibration lasts txtal*80*7*(n+4), n resetting to the default 7.
// [R5] the duration code spans 0h to Fh, from 560*4 to 560*19 periods.
// [R6] the 6-bit width select chooses the calibration bandwidth, reset 04h.
// [R7] unused bits read zero, ignore writes and drive no outputs.
module rpc_bank
(
	input  wire logic                       core_clk_i,
	input  wire logic                       arst_n_i,
	input  wire logic [rpc_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [rpc_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [rpc_pkg::DATA_W-1:0] rdata_o,
	output logic                            rf_path_disable_o,
	output logic      [3:0]                 if_attenuation_trim_o,
	output logic      [3:0]                 bandpass_cal_duration_o,
	output logic      [5:0]                 bandpass_cal_width_select_o,
	output logic      [14:0]                bandpass_cal_periods_o
);
	import rpc_pkg::*;

	rpc_regs_if regs ();

	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic        dis_reg;
	logic        dis_next;
	logic [3:0]  att_reg;
	logic [3:0]  att_next;
	logic [3:0]  dur_reg;
	logic [3:0]  dur_next;
	logic [5:0]  bw_reg;
	logic [5:0]  bw_next;
	logic [14:0] per_reg;
	logic [14:0] per_next;

	function automatic logic [2:0] dec_idx(input logic [9:0] a);
		// bit 2 flags a hit, bits 1:0 the register index
		unique case (a)
			RF_PATH_CONTROL_OFS:        dec_idx = 3'h4;
			BANDPASS_CAL_TIME_OFS:      dec_idx = 3'h5;
			BANDPASS_CAL_BANDWIDTH_OFS: dec_idx = 3'h6;
			default:                    dec_idx = 3'h0;
		endcase
	endfunction

	logic [2:0] wr_hit;
	logic [2:0] rd_hit;
	assign wr_hit        = dec_idx(addr_i);
	assign rd_hit        = dec_idx(addr_i);
	assign regs.wr_en    = wr_i && wr_hit[2];
	assign regs.wr_idx   = wr_hit[1:0];
	assign regs.wr_data  = wdata_i;

	rpc_reg_store u_store (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.bus        (regs)
	);

	always_comb begin
		// unmapped reads return zero; data only valid the cycle after rd_i
		rdata_next = 8'h00;
		if (rd_i && rd_hit[2]) begin
			rdata_next = regs.reg_q[rd_hit[1:0]]; // R7
		end
		dis_next = regs.reg_q[0][RF_PATH_DISABLE_BIT]; // R1
		att_next = regs.reg_q[0][IF_ATT_MSB:0]; // R2
		dur_next = regs.reg_q[1][CAL_DUR_MSB:0]; // R4
		bw_next  = regs.reg_q[2][CAL_BW_MSB:0]; // R6
		// duration in crystal periods, 2240 up to 10640
		per_next = 15'(CAL_MULT * (int'(dur_next) + CAL_ADD)); // R5
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= 8'h00;
			dis_reg   <= RF_PATH_CONTROL_RST[RF_PATH_DISABLE_BIT];
			att_reg   <= RF_PATH_CONTROL_RST[3:0];
			dur_reg   <= BANDPASS_CAL_TIME_RST[3:0];
			bw_reg    <= BANDPASS_CAL_BANDWIDTH_RST[5:0];
			per_reg   <= 15'(CAL_MULT * (int'(BANDPASS_CAL_TIME_RST[3:0])
				+ CAL_ADD));
		end else begin
			rdata_reg <= rdata_next;
			dis_reg   <= dis_next;
			att_reg   <= att_next;
			dur_reg   <= dur_next;
			bw_reg    <= bw_next;
			per_reg   <= per_next;
		end
	end

	assign rdata_o                     = rdata_reg;
	assign rf_path_disable_o           = dis_reg;
	assign if_attenuation_trim_o       = att_reg;
	assign bandpass_cal_duration_o     = dur_reg;
	assign bandpass_cal_width_select_o = bw_reg;
	assign bandpass_cal_periods_o      = per_reg;

	// every check below runs on core_clk_i and sleeps while reset is low
	sequence s_wr_ctl;
		wr_i && addr_i == RF_PATH_CONTROL_OFS;
	endsequence

	sequence s_wr_time;
		wr_i && addr_i == BANDPASS_CAL_TIME_OFS;
	endsequence

	sequence s_wr_bw;
		wr_i && addr_i == BANDPASS_CAL_BANDWIDTH_OFS;
	endsequence

	sequence s_rd_ctl;
		rd_i && addr_i == RF_PATH_CONTROL_OFS;
	endsequence

	sequence s_rd_time;
		rd_i && addr_i == BANDPASS_CAL_TIME_OFS;
	endsequence

	sequence s_rd_bw;
		rd_i && addr_i == BANDPASS_CAL_BANDWIDTH_OFS;
	endsequence

	// accesses that decode to none of the three offsets
	sequence s_wr_miss;
		wr_i && addr_i != RF_PATH_CONTROL_OFS
		&& addr_i != BANDPASS_CAL_TIME_OFS
		&& addr_i != BANDPASS_CAL_BANDWIDTH_OFS;
	endsequence

	sequence s_rd_miss;
		rd_i && addr_i != RF_PATH_CONTROL_OFS
		&& addr_i != BANDPASS_CAL_TIME_OFS
		&& addr_i != BANDPASS_CAL_BANDWIDTH_OFS;
	endsequence

	// control outputs lag the storage by one edge, so two after the strobe
	AST_RF_OFF: assert property ( // R1
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_ctl |-> ##2
		rf_path_disable_o == $past(wdata_i[RF_PATH_DISABLE_BIT], 2))
		else $error("rf path disable not following write");

	AST_ATT: assert property ( // R2
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_ctl |-> ##2
		if_attenuation_trim_o == $past(wdata_i[IF_ATT_MSB:0], 2))
		else $error("attenuation trim not following write");

	AST_DUR: assert property ( // R4
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_time |-> ##2
		bandpass_cal_duration_o == $past(wdata_i[CAL_DUR_MSB:0], 2))
		else $error("calibration duration not following write");

	AST_BW: assert property ( // R6
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_bw |-> ##2
		bandpass_cal_width_select_o == $past(wdata_i[CAL_BW_MSB:0], 2))
		else $error("calibration width not following write");

	AST_PER: assert property ( // R5
		@(posedge core_clk_i) disable iff (!arst_n_i)
		bandpass_cal_periods_o >= 15'h08C0
		&& bandpass_cal_periods_o <= 15'h2990)
		else $error("calibration period out of range");

	// both outputs load from the same stage, so they always agree
	AST_PER_EXACT: assert property ( // R4
		@(posedge core_clk_i) disable iff (!arst_n_i)
		bandpass_cal_periods_o == 15'(CAL_MULT
		* (int'(bandpass_cal_duration_o) + CAL_ADD)))
		else $error("calibration period not matching duration");

	AST_RD_CTL: assert property ( // R7
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_rd_ctl |=> rdata_o[7:5] == 3'h0)
		else $error("unused control bits read nonzero");

	// read data and control outputs come from the same storage snapshot
	AST_RD_CTL_VAL: assert property ( // R1
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_rd_ctl |=>
		rdata_o[4:0] == {rf_path_disable_o, if_attenuation_trim_o})
		else $error("control readback mismatch");

	AST_RD_TIME: assert property ( // R7
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_rd_time |=> rdata_o[7:4] == 4'h0)
		else $error("unused time bits read nonzero");

	AST_RD_TIME_VAL: assert property ( // R4
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_rd_time |=> rdata_o[3:0] == bandpass_cal_duration_o)
		else $error("duration readback mismatch");

	AST_RD_BW: assert property ( // R7
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_rd_bw |=> rdata_o == {2'h0, bandpass_cal_width_select_o})
		else $error("width readback mismatch");

	AST_RD_MISS: assert property ( // R7
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_rd_miss |=> rdata_o == 8'h00)
		else $error("unmapped read returned nonzero");

	AST_IDLE: assert property ( // R7
		@(posedge core_clk_i) disable iff (!arst_n_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read answer");

	AST_MISS_CTL: assert property ( // R7
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_miss |=> $stable(regs.reg_q[0]))
		else $error("unmapped write changed control byte");

	AST_MISS_TIME: assert property ( // R7
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_miss |=> $stable(regs.reg_q[1]))
		else $error("unmapped write changed time byte");

	AST_MISS_BW: assert property ( // R7
		@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_miss |=> $stable(regs.reg_q[2]))
		else $error("unmapped write changed width byte");

	// the path stays in its state while nobody rewrites the control byte
	AST_RF_HOLD: assert property ( // R1
		@(posedge core_clk_i) disable iff (!arst_n_i)
		$stable(regs.reg_q[0]) |=> $stable(rf_path_disable_o))
		else $error("rf path disable moved without a write");
endmodule

// ==== rf_path_and_bpf_cal_config_test.sv ====
// self-checking bench for the rf path and calibration config bank
// assumes rpc_pkg and the design files are compiled first
`timescale 1ns/1ps
module rf_path_and_bpf_cal_config_test;
	import rpc_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        arst_n_i   = 1'b0;
	logic [9:0]  addr_i     = 10'h000;
	logic [7:0]  wdata_i    = 8'h00;
	logic        wr_i       = 1'b0;
	logic        rd_i       = 1'b0;
	logic [7:0]  rdata_o;
	logic        rf_path_disable_o;
	logic [3:0]  if_attenuation_trim_o;
	logic [3:0]  bandpass_cal_duration_o;
	logic [5:0]  bandpass_cal_width_select_o;
	logic [14:0] bandpass_cal_periods_o;
	int          failures        = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	always #50 core_clk_i = ~core_clk_i;
	rpc_bank dut (.core_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .rf_path_disable_o, .if_attenuation_trim_o,
		.bandpass_cal_duration_o, .bandpass_cal_width_select_o,
		.bandpass_cal_periods_o);
	task automatic close_out;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [14:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask
	// outputs follow a write two edges after the strobe edge
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge core_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", {7'h00, exp}, {7'h00, rdata_o});
	endtask
	task automatic t_reset;
		chk("rf_off", 15'h0000, {14'h0, rf_path_disable_o});
		chk("trim", 15'h0007, {11'h0, if_attenuation_trim_o});
		chk("dur", 15'h0007, {11'h0, bandpass_cal_duration_o});
		chk("bw", 15'h0004, {9'h0, bandpass_cal_width_select_o});
		chk("periods", 15'h1810, bandpass_cal_periods_o);
		rd(RF_PATH_CONTROL_OFS, 8'h07);
		rd(BANDPASS_CAL_TIME_OFS, 8'h07);
		rd(BANDPASS_CAL_BANDWIDTH_OFS, 8'h04);
	endtask
	task automatic t_rf;
		wr(RF_PATH_CONTROL_OFS, 8'h15);
		chk("rf_off", 15'h0001, {14'h0, rf_path_disable_o});
		chk("trim", 15'h0005, {11'h0, if_attenuation_trim_o});
		wr(RF_PATH_CONTROL_OFS, 8'hEF);
		chk("rf_off", 15'h0000, {14'h0, rf_path_disable_o});
		chk("trim", 15'h000F, {11'h0, if_attenuation_trim_o});
		rd(RF_PATH_CONTROL_OFS, 8'h0F);
	endtask
	task automatic t_dur;
		logic [3:0] n [3] = '{4'h0, 4'h7, 4'hF};
		for (int i = 0; i < 3; i++) begin
			wr(BANDPASS_CAL_TIME_OFS, {4'hF, n[i]});
			chk("dur", {11'h0, n[i]}, {11'h0, bandpass_cal_duration_o});
			chk("periods", 15'(CAL_MULT * (n[i] + CAL_ADD)), bandpass_cal_periods_o);
			rd(BANDPASS_CAL_TIME_OFS, {4'h0, n[i]});
		end
	endtask
	task automatic t_bw;
		logic [5:0] c [5] = '{6'h04, 6'h0D, 6'h16, 6'h1F, 6'h27};
		for (int i = 0; i < 5; i++) begin
			wr(BANDPASS_CAL_BANDWIDTH_OFS, {2'h3, c[i]});
			chk("bw", {9'h0, c[i]}, {9'h0, bandpass_cal_width_select_o});
			rd(BANDPASS_CAL_BANDWIDTH_OFS, {2'h0, c[i]});
		end
		// a stray write just outside the bank must not land anywhere
		wr(10'h088, 8'hFF);
		wr(10'h08C, 8'hFF);
		rd(10'h08C, 8'h00);
		chk("bw", 15'h0027, {9'h0, bandpass_cal_width_select_o});
		chk("trim", 15'h000F, {11'h0, if_attenuation_trim_o});
	endtask
	// a reset pulse in mid-run must bring every output back to its default
	task automatic t_mid_reset;
		wr(RF_PATH_CONTROL_OFS, 8'h1A);
		chk("rf_off", 15'h0001, {14'h0, rf_path_disable_o});
		@(posedge core_clk_i);
		arst_n_i <= 1'b0;
		@(posedge core_clk_i);
		arst_n_i <= 1'b1;
		#1;
		t_reset();
	endtask
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		repeat (12) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		#1;
		t_reset();
		t_rf();
		t_dur();
		t_bw();
		t_mid_reset();
		close_out();
	end
endmodule
